/* bench/cc_comparator_control_asserts.sv */
// Purpose: Port checks for the comparator control block.
// Assumes: Bound to the design top.
// Notes: None.
`timescale 1ns/10ps
`include "cc_defines.svh"
module cc_comparator_control_asserts (
	input wire logic                clk,
	input wire logic                rst_n,
	input wire cc_pkg::cc_sfr_req_t sfr_req,
	input wire logic [7:0]          sfr_rdata,
	input wire logic                cmp_raw_in,
	input wire logic                overflow_pulse,
	input wire cc_pkg::cc_analog_t  analog_ctrl,
	input wire logic                raw_output,
	input wire logic                sync_output,
	input wire logic                irq
);
	import cc_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_on3;
		analog_ctrl.power_en [*3];
	endsequence
	sequence s_rd(a);
		sfr_req.rd && !sfr_req.wr && sfr_req.addr == a;
	endsequence
	a_raw_gated: assert property (raw_output == (cmp_raw_in & analog_ctrl.power_en))
		else $error("raw output wrong");
	a_off_sync_low: assert property (!analog_ctrl.power_en [*2] |-> !sync_output)
		else $error("sync output high while off");
	a_sync_two_stage: assert property (s_on3 |-> sync_output == $past(cmp_raw_in, 3))
		else $error("sync output lag wrong");
	a_flag_irq_holds: assert property (irq && !sfr_req.wr |=> irq)
		else $error("irq dropped without a write");
	a_irq_has_cause: assert property ($rose(irq) |-> $changed(sync_output) || $past(sfr_req.wr))
		else $error("irq rose without cause");
	a_mux_one_hot: assert property ($onehot0({analog_ctrl.pos_chan, analog_ctrl.pos_ldo})
		&& $onehot0({analog_ctrl.neg_chan, analog_ctrl.neg_gnd})) else $error("mux not one-hot");
	a_mode_reserved_zero: assert property (s_rd(`CC_ADDR_MODE) |=> sfr_rdata[6] == 1'b0
		&& sfr_rdata[3:2] == 2'b00) else $error("reserved mode bits set");
	a_result_off_low: assert property (s_rd(`CC_ADDR_CTRL) ##0 !analog_ctrl.power_en
		|=> !sfr_rdata[6]) else $error("result high while off");
endmodule
bind cc_comparator_control cc_comparator_control_asserts u_cc_comparator_control_asserts (
	.clk, .rst_n, .sfr_req, .sfr_rdata, .cmp_raw_in, .overflow_pulse, .analog_ctrl,
	.raw_output, .sync_output, .irq);

/* bench/cc_core_model.sv */
// Purpose: Behavioural analog comparator core.
// Assumes: The bench sets the compared level.
// Notes: An unpowered core drives low.
`timescale 1ns/10ps
module cc_core_model (
	input  wire cc_pkg::cc_analog_t analog_ctrl,
	input  wire logic               level,
	output logic                    cmp_raw_in
);
	import cc_pkg::*;
	assign cmp_raw_in = analog_ctrl.power_en & level;
endmodule

/* bench/tb.sv */
// Purpose: Self-checking bench for the comparator control block.
// Assumes: The core model follows lvl while powered.
// Notes: None.
`timescale 1ns/10ps
`include "cc_defines.svh"
module tb;
	import cc_pkg::*;
	logic        clk = 0, rst_n = 0, run = 1, overflow_pulse = 0, lvl = 0;
	logic        cmp_raw_in, raw_output, sync_output, irq;
	logic [7:0]  sfr_rdata;
	cc_sfr_req_t sfr_req = '0;
	cc_analog_t  analog_ctrl;
	int          err_count = 0, n_checks = 0;
	always #10 if (run) clk = ~clk;
	cc_comparator_control u_cc_comparator_control (.clk, .rst_n, .sfr_req, .sfr_rdata,
		.cmp_raw_in, .overflow_pulse, .analog_ctrl, .raw_output, .sync_output, .irq);
	cc_core_model u_cc_core_model (.analog_ctrl, .level(lvl), .cmp_raw_in);
	task automatic chk(input string s, input logic [7:0] e, g);
		n_checks++;
		if (g !== e) begin
			$display("[FAIL] %s exp %h got %h", s, e, g);
			err_count++;
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(posedge clk);
		sfr_req <= '{a, 1'b1, 1'b0, d};
		@(posedge clk);
		sfr_req.wr <= 1'b0;
		@(negedge clk);
	endtask
	task automatic rd(input logic [7:0] a, e, input string s);
		@(posedge clk);
		sfr_req <= '{a, 1'b0, 1'b1, 8'h00};
		@(posedge clk);
		sfr_req.rd <= 1'b0;
		@(negedge clk);
		chk(s, e, sfr_rdata);
	endtask
	task automatic put(input logic v);
		@(posedge clk);
		lvl <= v;
		repeat (3) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		#100000;
		err_count++;
		complete_run;
	end
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		rd(`CC_ADDR_MODE, `CC_MODE_RESET, "mode");
		rd(`CC_ADDR_MUX, `CC_MUX_RESET, "mux");
		rd(8'h9C, 8'h00, "gap");
		$display("reset test done");
		for (int i = 0; i < 16; i++) begin
			wr(`CC_ADDR_MUX, {i[3:0], i[3:0]});
			chk("pos", i < 8 ? 8'h01 << i : 8'h00, analog_ctrl.pos_chan);
			chk("neg", i < 8 ? 8'h01 << i : 8'h00, analog_ctrl.neg_chan);
			chk("ldo", i == 8 ? 8'h03 : 8'h00, {6'h0, analog_ctrl.pos_ldo, analog_ctrl.neg_gnd});
		end
		for (int m = 0; m < 4; m++) begin
			wr(`CC_ADDR_MODE, 8'(m));
			rd(`CC_ADDR_MODE, 8'(m), "resp");
			chk("core", 8'(m), {6'h0, analog_ctrl.resp_mode});
		end
		$display("decode test done");
		wr(`CC_ADDR_CTRL, 8'h8D);
		chk("hyst", 8'h8D, {analog_ctrl.power_en, 3'h0, analog_ctrl.pos_hyst, analog_ctrl.neg_hyst});
		wr(`CC_ADDR_CTRL, 8'h8D);
		wr(`CC_ADDR_MODE, 8'h30);
		put(1'b1);
		chk("rise", 8'h07, {5'h0, sync_output, raw_output, irq});
		rd(`CC_ADDR_CTRL, 8'hED, "rflag");
		put(1'b0);
		rd(`CC_ADDR_CTRL, 8'hBD, "flags");
		wr(`CC_ADDR_CTRL, 8'h8D);
		chk("clr", 8'h00, {7'h0, irq});
		wr(`CC_ADDR_MODE, 8'h00);
		put(1'b1);
		chk("mask", 8'h00, {7'h0, irq});
		@(posedge clk);
		overflow_pulse <= 1'b1;
		@(posedge clk);
		overflow_pulse <= 1'b0;
		put(1'b0);
		rd(`CC_ADDR_MODE, 8'h80, "sample");
		run = 0;
		lvl <= 1'b1;
		#5;
		chk("noclk", 8'h01, {7'h0, raw_output});
		run = 1;
		wr(`CC_ADDR_CTRL, 8'h00);
		@(negedge clk);
		chk("off", 8'h00, {5'h0, analog_ctrl.power_en, sync_output, raw_output});
		rd(`CC_ADDR_CTRL, 8'h00, "offrd");
		$display("edge test done");
		complete_run;
	end
endmodule

/* hw/cc_comparator_control.sv */
// Purpose: Digital control and status logic around an analog voltage comparator.
// Assumes: Special function register strobes and overflow pulse come from logic on clk.
// Notes: The raw output path is combinational so that it works with clk stopped.
`timescale 1ns/10ps
`include "cc_defines.svh"

module cc_comparator_control (
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire cc_pkg::cc_sfr_req_t sfr_req,
	output logic [7:0]              sfr_rdata,
	input  wire logic               cmp_raw_in,
	input  wire logic               overflow_pulse,
	output cc_pkg::cc_analog_t      analog_ctrl,
	output logic                    raw_output,
	output logic                    sync_output,
	output logic                    irq
);
	import cc_pkg::*;

	function automatic logic [8:0] decode_sel(input logic [3:0] sel);
		logic [8:0] hot;
		hot = 9'h000;
		if (sel <= `CC_SEL_LAST_CHAN) begin
			hot[sel[2:0]] = 1'b1;
		end else if (sel == `CC_SEL_INTERNAL) begin
			hot[8] = 1'b1;
		end
		return hot;
	endfunction

	logic [7:0] mode_reg;
	logic [7:0] ctrl_reg;
	logic [7:0] mux_reg;
	logic       sync_s1;
	logic       sync_s2;
	logic       sync_prev;
	logic       sampled_out;

	wire logic       wr_mode       = sfr_req.wr && (sfr_req.addr == `CC_ADDR_MODE);
	wire logic       wr_ctrl       = sfr_req.wr && (sfr_req.addr == `CC_ADDR_CTRL);
	wire logic       wr_mux        = sfr_req.wr && (sfr_req.addr == `CC_ADDR_MUX);
	wire logic       comparator_on = ctrl_reg[`CC_CTRL_ON];
	wire logic       compare_result = sync_s2 && comparator_on;
	wire logic       rise_seen     = comparator_on && sync_s2 && !sync_prev;
	wire logic       fall_seen     = comparator_on && !sync_s2 && sync_prev;
	wire logic       rise_edge_flag = ctrl_reg[`CC_CTRL_RISE_F];
	wire logic       fall_edge_flag = ctrl_reg[`CC_CTRL_FALL_F];
	wire logic       rise_irq_enable = mode_reg[`CC_MODE_RISE_IE];
	wire logic       fall_irq_enable = mode_reg[`CC_MODE_FALL_IE];
	wire logic [8:0] pos_hot       = decode_sel(mux_reg[3:0]);
	wire logic [8:0] neg_hot       = decode_sel(mux_reg[7:4]);

	// Software writes a flag as zero to clear it; a same-cycle edge still sets it.
	wire logic next_rise = rise_seen ||
		(wr_ctrl ? (rise_edge_flag && sfr_req.wdata[`CC_CTRL_RISE_F]) : rise_edge_flag);
	wire logic next_fall = fall_seen ||
		(wr_ctrl ? (fall_edge_flag && sfr_req.wdata[`CC_CTRL_FALL_F]) : fall_edge_flag);

	wire logic [7:0] next_ctrl = {
		wr_ctrl ? sfr_req.wdata[`CC_CTRL_ON] : comparator_on,
		1'b0,
		next_rise,
		next_fall,
		wr_ctrl ? sfr_req.wdata[3:0] : ctrl_reg[3:0]
	};

	// Reserved mode bits are never stored, so they always read their reset value.
	wire logic [7:0] next_mode = wr_mode ?
		{1'b0, 1'b0, sfr_req.wdata[5:4], 2'b00, sfr_req.wdata[1:0]} :
		{1'b0, 1'b0, mode_reg[5:4], 2'b00, mode_reg[1:0]};

	wire logic [7:0] mode_view = {sampled_out, mode_reg[6:0]};
	wire logic [7:0] ctrl_view = {comparator_on, compare_result, ctrl_reg[5:0]};

	wire logic [7:0] read_mux =
		(sfr_req.addr == `CC_ADDR_MODE) ? mode_view :
		(sfr_req.addr == `CC_ADDR_CTRL) ? ctrl_view :
		(sfr_req.addr == `CC_ADDR_MUX)  ? mux_reg   : 8'h00;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_reg <= `CC_MODE_RESET;
			ctrl_reg <= `CC_CTRL_RESET;
			mux_reg  <= `CC_MUX_RESET;
		end else begin
			mode_reg <= next_mode;
			ctrl_reg <= next_ctrl;
			mux_reg  <= wr_mux ? sfr_req.wdata : mux_reg;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_s1   <= 1'b0;
			sync_s2   <= 1'b0;
			sync_prev <= 1'b0;
		end else begin
			sync_s1   <= cmp_raw_in;
			sync_s2   <= sync_s1;
			sync_prev <= sync_s2;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sampled_out <= 1'b0;
		end else if (overflow_pulse) begin
			sampled_out <= compare_result;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sfr_rdata   <= 8'h00;
			sync_output <= 1'b0;
		end else begin
			sfr_rdata   <= sfr_req.rd ? read_mux : sfr_rdata;
			sync_output <= compare_result;
		end
	end

	// The raw path has no flip-flop so it keeps following the core with clk stopped.
	assign raw_output = cmp_raw_in && comparator_on;

	assign irq = (rise_edge_flag && rise_irq_enable) ||
		(fall_edge_flag && fall_irq_enable);

	always_comb begin
		analog_ctrl.power_en  = comparator_on;
		analog_ctrl.pos_chan  = pos_hot[7:0];
		analog_ctrl.pos_ldo   = pos_hot[8];
		analog_ctrl.neg_chan  = neg_hot[7:0];
		analog_ctrl.neg_gnd   = neg_hot[8];
		analog_ctrl.pos_hyst  = ctrl_reg[`CC_CTRL_PHYS_HI:`CC_CTRL_PHYS_LO];
		analog_ctrl.neg_hyst  = ctrl_reg[`CC_CTRL_NHYS_HI:`CC_CTRL_NHYS_LO];
		analog_ctrl.resp_mode = mode_reg[`CC_MODE_RESP_HI:`CC_MODE_RESP_LO];
	end

endmodule

/* inc/cc_defines.svh */
// Purpose: Register offsets, field positions and reset values of the comparator control block.
// Assumes: Eight-bit special function register space.
// Notes: Definitions only.
`ifndef CC_DEFINES_SVH
`define CC_DEFINES_SVH

`define CC_ADDR_MODE      8'h9D
`define CC_ADDR_CTRL      8'h9B
`define CC_ADDR_MUX       8'h9F

`define CC_MODE_RESET     8'h02
`define CC_CTRL_RESET     8'h00
`define CC_MUX_RESET      8'hFF

`define CC_MODE_SAMPLED   7
`define CC_MODE_RISE_IE   5
`define CC_MODE_FALL_IE   4
`define CC_MODE_RESP_HI   1
`define CC_MODE_RESP_LO   0

`define CC_CTRL_ON        7
`define CC_CTRL_RESULT    6
`define CC_CTRL_RISE_F    5
`define CC_CTRL_FALL_F    4
`define CC_CTRL_PHYS_HI   3
`define CC_CTRL_PHYS_LO   2
`define CC_CTRL_NHYS_HI   1
`define CC_CTRL_NHYS_LO   0

`define CC_SEL_LAST_CHAN  4'h7
`define CC_SEL_INTERNAL   4'h8

`endif

/* inc/cc_pkg.sv */
// Purpose: Types shared by the comparator control block and its surroundings.
// Assumes: Analog core takes one-hot channel enables.
// Notes: None.
package cc_pkg;

	typedef struct packed {
		logic       power_en;
		logic [7:0] pos_chan;
		logic       pos_ldo;
		logic [7:0] neg_chan;
		logic       neg_gnd;
		logic [1:0] pos_hyst;
		logic [1:0] neg_hyst;
		logic [1:0] resp_mode;
	} cc_analog_t;

	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} cc_sfr_req_t;

endpackage
